// ==== rtl/qrb_pkg.sv ====
package qrb_pkg;
  localparam logic [7:0] QRB_OFS_QUERY_LO = 8'h20;
  localparam logic [7:0] QRB_OFS_QUERY_HI = 8'h27;
  localparam logic [7:0] QRB_OFS_STATUS_QUERY = 8'h22;
  localparam logic [7:0] QRB_OFS_DEVICE_INFO_QUERY = 8'h23;
  localparam logic [7:0] QRB_OFS_LIST_POINT_QUERY = 8'h24;
  localparam logic [7:0] QRB_OFS_DAC_VALUE_QUERY = 8'h25;
  localparam logic [7:0] QRB_OFS_SPI_READOUT_BUFFER = 8'h26;

  localparam int QRB_DATA_W = 64;
  localparam int QRB_CMD_W = 56;
  localparam int QRB_LIST_DEPTH = 2048;
  localparam int QRB_LIST_AW = 11;
  localparam int QRB_LIST_W = 80;
  localparam int QRB_AMP_W = 16;
  localparam int QRB_LOCK_W = 7;
  localparam int QRB_SHIFT_CNT_W = 6;

  // Status word bit positions
  localparam int QRB_ST_LIST_RUN = 24;
  localparam int QRB_ST_STANDBY = 20;
  localparam int QRB_ST_PULSE_EN = 19;
  localparam int QRB_ST_AUTO_LEVEL = 18;
  localparam int QRB_ST_LOOP_OPEN = 17;
  localparam int QRB_ST_DC_PHASE = 12;
  localparam int QRB_ST_LOCK_LO = 0;

  // Lock vector bit positions, same as status word
  localparam int QRB_LK_MAIN = 0;
  localparam int QRB_LK_FINE = 2;
  localparam int QRB_LK_VCXO = 5;
  localparam int QRB_LK_OCXO = 6;

  // Query field positions
  localparam int QRB_INFO_SEL_HI = 2;
  localparam int QRB_LIST_IDX_HI = 15;
  localparam int QRB_LIST_SEL_BIT = 23;
  localparam int QRB_DAC_SEL_BIT = 0;

  localparam logic [2:0] QRB_INFO_SERIAL = 3'h0;
  localparam logic [2:0] QRB_INFO_HW_REV = 3'h1;
  localparam logic [2:0] QRB_INFO_FW_REV = 3'h2;
  localparam logic [2:0] QRB_INFO_DATE = 3'h3;

  localparam logic [63:0] QRB_BUF_RESET = 64'h0;
  localparam logic [5:0] QRB_SHIFT_LAST = 6'h3F;

  typedef enum logic [1:0] {
    QRB_IDLE = 2'b01,
    QRB_LIST_WAIT = 2'b10
  } qrb_state_e;
endpackage

// ==== rtl/qrb_list_mem.sv ====
`timescale 1ns/10ps
module qrb_list_mem
  import qrb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic wr_en,
  input wire logic [QRB_LIST_AW-1:0] wr_addr,
  input wire logic [QRB_LIST_W-1:0] wr_data,
  input wire logic [QRB_LIST_AW-1:0] rd_addr,
  output logic [QRB_LIST_W-1:0] rd_data
);
  logic [QRB_LIST_W-1:0] mem [QRB_LIST_DEPTH];

  // No reset on the array so it maps onto block RAM
  always_ff @(posedge clk_sys)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    rd_data <= mem[rd_addr];
  end
endmodule // qrb_list_mem

// ==== rtl/qrb_query_regs.sv ====
`timescale 1ns/10ps
// Function
// - Status bit 24 shows list running
// - Status bit 20 shows synthesizer standby
// - Status bit 19 shows pulse control enabled
// - Status bit 18 shows auto level adjust
// - Status bit 17 shows level loop open
// - Status bit 12 shows DC phase continuation
// - Status bit 0 shows main loop lock
// - Status bit 6 shows 10 MHz reference lock
// - Bits 5 and 2 show VCXO, fine lock
// - Info query loads selected item into buffer
// - Selector: serial, hw rev, fw rev, date
// - Date packed year, month, day, hour
// - SPI results wait; USB results immediate
// - List query returns frequency or amplitude
// - Amplitude magnitude 14:0, sign bit 15
// - DAC query selects high or low DAC
// - SPI readout shifts last query result
// - Status query loads current status
module qrb_query_regs
  import qrb_pkg::*;
#(
  // Arbitrary identity values, replace per unit
  parameter logic [31:0] SERIAL_NUMBER = 32'h0000_0001,
  parameter logic [31:0] HW_REVISION = 32'h3F80_0000,
  parameter logic [31:0] FW_REVISION = 32'h3F80_0000,
  parameter logic [7:0] MFG_YEAR = 8'h01,
  parameter logic [7:0] MFG_MONTH = 8'h01,
  parameter logic [7:0] MFG_DAY = 8'h01,
  parameter logic [7:0] MFG_HOUR = 8'h00
)
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_addr,
  input wire logic [QRB_CMD_W-1:0] cmd_data,
  input wire logic cmd_is_spi,
  input wire logic ext_result_valid,
  input wire logic [QRB_DATA_W-1:0] ext_result_data,
  input wire logic list_running,
  input wire logic synth_standby,
  input wire logic pulse_enable,
  input wire logic auto_level_adjust,
  input wire logic level_control_loop_open,
  input wire logic dc_phase_continue,
  input wire logic [31:8] op_misc_flags,
  input wire logic [QRB_LOCK_W-1:0] lock_pins,
  input wire logic [15:0] hf_level_dac,
  input wire logic [15:0] lf_amp_dac,
  input wire logic list_wr_en,
  input wire logic [QRB_LIST_AW-1:0] list_wr_addr,
  input wire logic [QRB_LIST_W-1:0] list_wr_data,
  input wire logic spi_shift,
  output logic [QRB_DATA_W-1:0] usb_readback,
  output logic usb_readback_valid,
  output logic [QRB_DATA_W-1:0] spi_out_buffer,
  output logic spi_miso_bit,
  output logic spi_readout_active
);
  qrb_state_e state_reg;
  logic [QRB_LOCK_W-1:0] lock_meta_reg;
  logic [QRB_LOCK_W-1:0] lock_sync_reg;
  logic [QRB_DATA_W-1:0] shift_reg;
  logic [QRB_SHIFT_CNT_W-1:0] shift_cnt_reg;
  logic list_sel_amp_reg;
  logic list_idx_bad_reg;
  logic list_spi_reg;
  logic [QRB_LIST_AW-1:0] list_rd_addr;
  logic [QRB_LIST_W-1:0] list_rd_data;
  logic [QRB_DATA_W-1:0] status_word;
  logic [QRB_DATA_W-1:0] info_word;
  logic [QRB_DATA_W-1:0] dac_word;
  logic [QRB_DATA_W-1:0] list_word;
  logic cmd_take;
  logic result_load;
  logic result_spi;
  logic [QRB_DATA_W-1:0] result_data;

  function automatic logic is_query(input logic [7:0] addr);
    is_query = (addr >= QRB_OFS_QUERY_LO) && (addr <= QRB_OFS_QUERY_HI)
      && (addr != QRB_OFS_SPI_READOUT_BUFFER);
  endfunction

  function automatic logic is_readout(input logic [7:0] addr,
    input logic spi);
    is_readout = spi && (addr == QRB_OFS_SPI_READOUT_BUFFER);
  endfunction

  // Lock indicators come from analog loops, not this clock
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      lock_meta_reg <= '0;
      lock_sync_reg <= '0;
    end
    else
    begin
      lock_meta_reg <= lock_pins;
      lock_sync_reg <= lock_meta_reg;
    end
  end

  always_comb
  begin
    status_word = QRB_BUF_RESET;
    status_word[31:8] = op_misc_flags;
    status_word[QRB_ST_LIST_RUN] = list_running;
    status_word[QRB_ST_STANDBY] = synth_standby;
    status_word[QRB_ST_PULSE_EN] = pulse_enable;
    status_word[QRB_ST_AUTO_LEVEL] = auto_level_adjust;
    status_word[QRB_ST_LOOP_OPEN] = level_control_loop_open;
    status_word[QRB_ST_DC_PHASE] = dc_phase_continue;
    status_word[QRB_LOCK_W-1:QRB_ST_LOCK_LO] = lock_sync_reg;
  end

  always_comb
  begin
    info_word = QRB_BUF_RESET;
    case (cmd_data[QRB_INFO_SEL_HI:0])
      QRB_INFO_SERIAL: info_word[31:0] = SERIAL_NUMBER;
      QRB_INFO_HW_REV: info_word[31:0] = HW_REVISION;
      QRB_INFO_FW_REV: info_word[31:0] = FW_REVISION;
      QRB_INFO_DATE:
        info_word[31:0] = {MFG_YEAR, MFG_MONTH, MFG_DAY, MFG_HOUR};
      default: info_word = QRB_BUF_RESET;
    endcase
  end

  always_comb
  begin
    dac_word = QRB_BUF_RESET;
    if (cmd_data[QRB_DAC_SEL_BIT])
    begin
      dac_word[15:0] = lf_amp_dac;
    end
    else
    begin
      dac_word[15:0] = hf_level_dac;
    end
  end

  // Memory word holds amplitude above the 64-bit frequency
  always_comb
  begin
    list_word = QRB_BUF_RESET;
    if (list_idx_bad_reg)
    begin
      list_word = QRB_BUF_RESET;
    end
    else if (list_sel_amp_reg)
    begin
      list_word[QRB_AMP_W-1:0] = list_rd_data[QRB_LIST_W-1:QRB_DATA_W];
    end
    else
    begin
      list_word = list_rd_data[QRB_DATA_W-1:0];
    end
  end

  // Stall new commands while the list memory read is in flight
  assign cmd_ready = (state_reg == QRB_IDLE);
  assign cmd_take = cmd_valid && cmd_ready;
  assign list_rd_addr = cmd_data[QRB_LIST_AW-1:0];

  qrb_list_mem u_list_mem (
    .clk_sys(clk_sys),
    .wr_en(list_wr_en),
    .wr_addr(list_wr_addr),
    .wr_data(list_wr_data),
    .rd_addr(list_rd_addr),
    .rd_data(list_rd_data)
  );

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      state_reg <= QRB_IDLE;
      list_sel_amp_reg <= 1'b0;
      list_idx_bad_reg <= 1'b0;
      list_spi_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        QRB_IDLE:
        begin
          if (cmd_take && cmd_addr == QRB_OFS_LIST_POINT_QUERY)
          begin
            state_reg <= QRB_LIST_WAIT;
            list_sel_amp_reg <= cmd_data[QRB_LIST_SEL_BIT];
            // Index past the table returns zeros rather than aliasing
            list_idx_bad_reg <=
              |cmd_data[QRB_LIST_IDX_HI:QRB_LIST_AW];
            list_spi_reg <= cmd_is_spi;
          end
        end
        QRB_LIST_WAIT:
        begin
          state_reg <= QRB_IDLE;
        end
        default:
        begin
          state_reg <= QRB_IDLE;
        end
      endcase
    end
  end

  always_comb
  begin
    result_load = 1'b0;
    result_spi = cmd_is_spi;
    result_data = QRB_BUF_RESET;
    if (state_reg == QRB_LIST_WAIT)
    begin
      result_load = 1'b1;
      result_spi = list_spi_reg;
      result_data = list_word;
    end
    else if (cmd_take && is_query(cmd_addr))
    begin
      case (cmd_addr)
        QRB_OFS_STATUS_QUERY:
        begin
          result_load = 1'b1;
          result_data = status_word;
        end
        QRB_OFS_DEVICE_INFO_QUERY:
        begin
          result_load = 1'b1;
          result_data = info_word;
        end
        QRB_OFS_DAC_VALUE_QUERY:
        begin
          result_load = 1'b1;
          result_data = dac_word;
        end
        default:
        begin
          result_load = 1'b0;
        end
      endcase
    end
    else if (ext_result_valid)
    begin
      result_load = 1'b1;
      result_data = ext_result_data;
    end
  end

  // USB side sees every non-SPI result at once, except an ext result that meets a taken query or the list wait and is dropped
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      usb_readback <= QRB_BUF_RESET;
      usb_readback_valid <= 1'b0;
    end
    else
    begin
      usb_readback_valid <= result_load && !result_spi;
      if (result_load && !result_spi)
      begin
        usb_readback <= result_data;
      end
    end
  end

  // SPI results park here until the readout transfer takes them
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      spi_out_buffer <= QRB_BUF_RESET;
    end
    else if (result_load && result_spi)
    begin
      spi_out_buffer <= result_data;
    end
    else if (cmd_take && is_readout(cmd_addr, cmd_is_spi))
    begin
      spi_out_buffer <= QRB_BUF_RESET;
    end
  end

  // Readout register is ignored on USB; only SPI loads the shifter
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      shift_reg <= QRB_BUF_RESET;
    end
    else if (cmd_take && is_readout(cmd_addr, cmd_is_spi))
    begin
      shift_reg <= spi_out_buffer;
    end
    else if (spi_readout_active && spi_shift)
    begin
      shift_reg <= {shift_reg[QRB_DATA_W-2:0], 1'b0};
    end
  end

  // Counts the 64 bit times of one readout
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      shift_cnt_reg <= '0;
    end
    else if (cmd_take && is_readout(cmd_addr, cmd_is_spi))
    begin
      shift_cnt_reg <= '0;
    end
    else if (spi_readout_active && spi_shift)
    begin
      shift_cnt_reg <= shift_cnt_reg + 6'h01;
    end
  end

  // A new readout request restarts a transfer already under way
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      spi_readout_active <= 1'b0;
    end
    else if (cmd_take && is_readout(cmd_addr, cmd_is_spi))
    begin
      spi_readout_active <= 1'b1;
    end
    else if (spi_readout_active && spi_shift
      && shift_cnt_reg == QRB_SHIFT_LAST)
    begin
      spi_readout_active <= 1'b0;
    end
  end

  assign spi_miso_bit = shift_reg[QRB_DATA_W-1];
endmodule // qrb_query_regs

// ==== testbench/qrb_query_regs_properties.sv ====
`timescale 1ns/10ps
module qrb_chk
  import qrb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [7:0] cmd_addr,
  input wire logic [QRB_CMD_W-1:0] cmd_data,
  input wire logic cmd_is_spi,
  input wire logic list_running,
  input wire logic synth_standby,
  input wire logic pulse_enable,
  input wire logic auto_level_adjust,
  input wire logic level_control_loop_open,
  input wire logic dc_phase_continue,
  input wire logic [15:0] hf_level_dac,
  input wire logic [15:0] lf_amp_dac,
  input wire logic [QRB_DATA_W-1:0] usb_readback,
  input wire logic usb_readback_valid,
  input wire logic [QRB_DATA_W-1:0] spi_out_buffer,
  input wire logic spi_miso_bit,
  input wire logic spi_readout_active
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic take;
  logic [5:0] flags;
  logic [5:0] st;
  logic [15:0] dac_sel;
  assign take = cmd_valid && cmd_ready;
  assign flags = {list_running, synth_standby, pulse_enable,
    auto_level_adjust, level_control_loop_open, dc_phase_continue};
  assign st = {usb_readback[24], usb_readback[20:17], usb_readback[12]};
  assign dac_sel = cmd_data[0] ? lf_amp_dac : hf_level_dac;

  status_load_a: assert property (take && !cmd_is_spi
    && cmd_addr == 8'h22 |=> usb_readback_valid && usb_readback[63:32] == 0)
    else $error("status query gave no result");
  status_flags_a: assert property (
    take && !cmd_is_spi && cmd_addr == 8'h22 |=> st == $past(flags))
    else $error("status flags wrong");
  list_stall_a: assert property (take && cmd_addr == 8'h24
    |=> !cmd_ready ##1 cmd_ready)
    else $error("list query stall wrong");
  dac_pick_a: assert property (
    take && !cmd_is_spi && cmd_addr == 8'h25
    |=> usb_readback == {48'h0, $past(dac_sel)})
    else $error("dac value wrong");
  spi_defer_a: assert property (take && cmd_is_spi
    && cmd_addr == 8'h22 |=> !usb_readback_valid)
    else $error("spi result shown on usb");
  info_upper_a: assert property (take && !cmd_is_spi
    && cmd_addr == 8'h23 |=> usb_readback_valid && usb_readback[63:32] == 0)
    else $error("info result wrong");
  readout_start_a: assert property (take && cmd_is_spi
    && cmd_addr == 8'h26 |=> spi_readout_active
    && spi_miso_bit == $past(spi_out_buffer[63]) && spi_out_buffer == 0)
    else $error("readout start wrong");
  usb_refuse_a: assert property (take && !cmd_is_spi
    && cmd_addr == 8'h26 && !spi_readout_active |=> !spi_readout_active)
    else $error("usb readout not refused");
endmodule // qrb_chk

// ==== testbench/qrb_host_model.sv ====
`timescale 1ns/10ps
module qrb_host_model
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic spi_miso_bit,
  input wire logic spi_readout_active,
  output logic spi_shift,
  output logic [63:0] rx_word
);
  // Capture before pulsing, so a bit is never taken while it moves
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      spi_shift <= 1'b0;
      rx_word <= 64'h0;
    end
    else
    begin
      spi_shift <= 1'b0;
      if (spi_readout_active && !spi_shift)
      begin
        rx_word <= {rx_word[62:0], spi_miso_bit};
        spi_shift <= 1'b1;
      end
    end
  end
endmodule // qrb_host_model

// ==== testbench/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_is_spi = 1'b0;
  logic list_wr_en = 1'b0;
  logic [7:0] cmd_addr = 8'h00;
  logic [55:0] cmd_data = 56'h0;
  logic [5:0] flags = 6'h2B;
  logic [10:0] list_wr_addr = 11'h000;
  logic [79:0] list_wr_data = 80'h0;
  logic ext_result_valid = 1'b0;
  logic [63:0] ext_result_data = 64'h0;
  logic [23:0] op_misc_flags = 24'h0;
  logic [6:0] lock_pins = 7'h65;
  logic [15:0] hf_level_dac = 16'hA5C3;
  logic [15:0] lf_amp_dac = 16'h3C5A;
  logic cmd_ready, usb_readback_valid, spi_miso_bit, spi_readout_active;
  logic spi_shift;
  logic [63:0] usb_readback, spi_out_buffer, got, host_word;
  logic [127:0] rows [11];
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;

  always #2 clk_sys = ~clk_sys;

  qrb_query_regs #(.SERIAL_NUMBER(32'h1234_5678),
    .HW_REVISION(32'h4000_0000), .MFG_YEAR(8'h24), .MFG_MONTH(8'h06),
    .MFG_HOUR(8'h09))
  u_dut (.clk_sys(clk_sys), .reset(reset), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .cmd_is_spi(cmd_is_spi), .ext_result_valid(ext_result_valid),
    .ext_result_data(ext_result_data), .list_running(flags[5]),
    .synth_standby(flags[4]), .pulse_enable(flags[3]),
    .auto_level_adjust(flags[2]), .level_control_loop_open(flags[1]),
    .dc_phase_continue(flags[0]), .op_misc_flags(op_misc_flags),
    .lock_pins(lock_pins), .hf_level_dac(hf_level_dac),
    .lf_amp_dac(lf_amp_dac),
    .list_wr_en(list_wr_en), .list_wr_addr(list_wr_addr),
    .list_wr_data(list_wr_data), .spi_shift(spi_shift),
    .usb_readback(usb_readback), .usb_readback_valid(usb_readback_valid),
    .spi_out_buffer(spi_out_buffer), .spi_miso_bit(spi_miso_bit),
    .spi_readout_active(spi_readout_active));

  qrb_host_model u_host (.clk_sys(clk_sys), .reset(reset),
    .spi_miso_bit(spi_miso_bit), .spi_readout_active(spi_readout_active),
    .spi_shift(spi_shift), .rx_word(host_word));

  task automatic give_verdict();
    if (fail_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    check_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask

  // Drops valid at the take edge; next call waits an edge first
  task automatic cmd(input logic [7:0] a, input logic [55:0] d,
    input logic s);
    @(posedge clk_sys);
    cmd_addr <= a;
    cmd_data <= d;
    cmd_is_spi <= s;
    cmd_valid <= 1'b1;
    @(posedge clk_sys);
    while (cmd_ready !== 1'b1)
      @(posedge clk_sys);
    cmd_valid <= 1'b0;
  endtask

  task automatic getr(output logic [63:0] r);
    int n;
    n = 0;
    #1;
    while (usb_readback_valid !== 1'b1 && n < 4)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    r = (usb_readback_valid === 1'b1) ? usb_readback : 'x;
  endtask

  // Waits out one 64-bit readout, bounded
  task automatic drain();
    repeat (2) @(posedge clk_sys);
    for (int n = 0; n < 300 && spi_readout_active === 1'b1; n++)
      @(posedge clk_sys);
    #1;
  endtask

  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      fail_count++;
      give_verdict();
    end
  end

  initial
  begin
    rows[0] = {8'h22, 56'h0, 64'h010A_1065};
    rows[1] = {8'h23, 56'h0, 64'h1234_5678};
    rows[2] = {8'h23, 56'h1, 64'h4000_0000};
    rows[3] = {8'h23, 56'h2, 64'h3F80_0000};
    rows[4] = {8'h23, 56'h3, 64'h2406_0109};
    rows[5] = {8'h23, 56'h5, 64'h0};
    rows[6] = {8'h24, 56'h0, 64'h0000_0574_FBDE_6000};
    rows[7] = {8'h24, 56'h80_07FF, 64'h8123};
    rows[8] = {8'h24, 56'h7FF, 64'h0123_4567_89AB_CDEF};
    rows[9] = {8'h25, 56'h0, 64'hA5C3};
    rows[10] = {8'h25, 56'h1, 64'h3C5A};
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk(usb_readback | spi_out_buffer, 64'h0);
    chk({61'h0, cmd_ready, spi_readout_active, usb_readback_valid}, 64'h4);
    @(posedge clk_sys);
    list_wr_en <= 1'b1;
    list_wr_data <= {16'h0001, 64'h0000_0574_FBDE_6000};
    @(posedge clk_sys);
    list_wr_addr <= 11'h7FF;
    list_wr_data <= {16'h8123, 64'h0123_4567_89AB_CDEF};
    @(posedge clk_sys);
    list_wr_en <= 1'b0;
    for (int i = 0; i < 11; i++)
    begin
      cmd(rows[i][127:120], rows[i][119:64], 1'b0);
      getr(got);
      chk(got, rows[i][63:0]);
    end
    cmd(8'h22, 56'h0, 1'b1);
    cmd(8'h26, 56'h0, 1'b1);
    drain();
    chk(host_word, 64'h010A_1065);
    chk(spi_out_buffer, 64'h0);
    cmd(8'h26, 56'h0, 1'b0);
    repeat (2) @(posedge clk_sys);
    #1;
    chk({63'h0, spi_readout_active}, 64'h0);
    @(posedge clk_sys);
    op_misc_flags <= 24'hFF_FFFF;
    lock_pins <= 7'h1A;
    repeat (2) @(posedge clk_sys);
    cmd(8'h22, 56'h0, 1'b0);
    getr(got);
    chk(got, 64'hFFEB_FF1A);
    @(posedge clk_sys);
    ext_result_data <= 64'h0F1E_2D3C_4B5A_6978;
    ext_result_valid <= 1'b1;
    @(posedge clk_sys);
    ext_result_valid <= 1'b0;
    getr(got);
    chk(got, 64'h0F1E_2D3C_4B5A_6978);
    @(posedge clk_sys);
    cmd_is_spi <= 1'b1;
    ext_result_data <= 64'h8000_0000_0000_0001;
    ext_result_valid <= 1'b1;
    @(posedge clk_sys);
    ext_result_valid <= 1'b0;
    cmd(8'h26, 56'h0, 1'b1);
    drain();
    chk(host_word, 64'h8000_0000_0000_0001);
    @(posedge clk_sys);
    reset <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk(usb_readback | spi_out_buffer, 64'h0);
    @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk({61'h0, cmd_ready, spi_readout_active, usb_readback_valid}, 64'h4);
    cmd(8'h22, 56'h0, 1'b0);
    getr(got);
    chk(got, 64'hFFEB_FF1A);
    give_verdict();
  end
endmodule // tb_top

bind qrb_query_regs qrb_chk u_chk (.clk_sys, .reset, .cmd_valid, .cmd_ready,
  .cmd_addr, .cmd_data, .cmd_is_spi, .list_running, .synth_standby,
  .pulse_enable, .auto_level_adjust, .level_control_loop_open,
  .dc_phase_continue, .hf_level_dac, .lf_amp_dac, .usb_readback,
  .usb_readback_valid, .spi_out_buffer, .spi_miso_bit, .spi_readout_active);
